/* File: inc/cuvx_cfg.svh */
// Constants for the cell undervoltage alert and extremum status block.
`ifndef CUVX_CFG_SVH
`define CUVX_CFG_SVH
`define CUVX_NCELL 14
`define CUVX_WORD_W 16
`define CUVX_IDX_W 4
`define CUVX_ADDR_W 12
`define CUVX_IDX_ALERTS 8'h09
`define CUVX_IDX_EXTREMUM 8'h0a
`define CUVX_IDX_UTHR 8'h10
`define CUVX_IDX_BTHR 8'h11
`define CUVX_IDX_ALERT_EN 8'h12
`define CUVX_IDX_POLARITY 8'h13
`define CUVX_IDX_CELL_EN 8'h14
`define CUVX_IDX_CTRL 8'h15
`define CUVX_IDX_IRQ_STAT 8'h16
`define CUVX_IDX_IRQ_MASK 8'h17
`define CUVX_RST_WORD 16'h0000
`define CUVX_RST_CELLS 14'h0000
`define CUVX_RST_IDX 4'h0
`define CUVX_IDX_INVALID 4'hf
`define CUVX_HI_LSB 8
`define CUVX_LO_LSB 0
`define CUVX_CTRL_FILT 0
`define CUVX_CTRL_SET 1
`define CUVX_NEV 3
`define CUVX_EV_ACQ 0
`define CUVX_EV_ALERT 1
`define CUVX_EV_INVALID 2
`endif

/* File: inc/cuvx_pkg.sv */
// Types and shared compare function for the cell undervoltage status block.
package cuvx_pkg;
  `include "cuvx_cfg.svh"
  typedef logic [`CUVX_WORD_W-1:0] cuvx_word_t;
  typedef logic [`CUVX_NCELL-1:0][`CUVX_WORD_W-1:0] cuvx_cells_t;
  typedef enum logic [1:0] {CUVX_M_IDLE = 2'b01, CUVX_M_WAIT = 2'b10} cuvx_mstate_t;
  typedef enum logic [2:0] {CUVX_S_IDLE = 3'b001, CUVX_S_RUN = 3'b010, CUVX_S_DONE = 3'b100} cuvx_sstate_t;

  // Greater-than on a unipolar (unsigned) or bipolar (signed) reading.
  function automatic logic cuvx_greater(input cuvx_word_t a, input cuvx_word_t b, input logic sgn);
    cuvx_greater = sgn ? ($signed(a) > $signed(b)) : (a > b);
  endfunction

  typedef struct packed {
    cuvx_mstate_t st;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    cuvx_word_t uthr;
    cuvx_word_t bthr;
    logic [`CUVX_NCELL-1:0] alert_en;
    logic [`CUVX_NCELL-1:0] pol;
    logic [`CUVX_NCELL-1:0] cell_en;
    logic filt;
    logic set_sel;
    logic [`CUVX_NEV-1:0] irq_stat;
    logic [`CUVX_NEV-1:0] irq_mask;
    logic irq;
    logic summary;
    logic [`CUVX_NCELL-1:0] alerts;
    logic [`CUVX_NCELL-1:0] pend;
    logic [`CUVX_IDX_W-1:0] hi;
    logic [`CUVX_IDX_W-1:0] lo;
    logic sweep;
    logic start;
    logic [`CUVX_NCELL-1:0] incl;
    logic sgn;
    cuvx_cells_t data;
  } cuvx_main_t;

  typedef struct packed {
    cuvx_sstate_t st;
    logic [`CUVX_IDX_W-1:0] idx;
    logic any;
    cuvx_word_t hi_val;
    cuvx_word_t lo_val;
    logic [`CUVX_IDX_W-1:0] hi_idx;
    logic [`CUVX_IDX_W-1:0] lo_idx;
    logic done;
  } cuvx_srch_t;
endpackage

/* File: inc/cuvx_search_if.sv */
// Carrier between the status top and its extremum search engine.
`timescale 1ns/1ps
`include "cuvx_cfg.svh"
interface cuvx_search_if;
  logic start;
  cuvx_pkg::cuvx_cells_t data;
  logic [`CUVX_NCELL-1:0] incl;
  logic sgn;
  logic done;
  logic [`CUVX_IDX_W-1:0] hi_idx;
  logic [`CUVX_IDX_W-1:0] lo_idx;
  modport ctl (output start, output data, output incl, output sgn, input done, input hi_idx, input lo_idx);
  modport eng (input start, input data, input incl, input sgn, output done, output hi_idx, output lo_idx);
endinterface

/* File: rtl/cuvx_extremum.sv */
// Sequential search for the highest and lowest cell among a selected set.
`timescale 1ns/1ps
`include "cuvx_cfg.svh"
module cuvx_extremum (
  input wire logic clock, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  cuvx_search_if.eng sif // Search request and result.
);
  import cuvx_pkg::*;

  cuvx_srch_t s_q;
  cuvx_srch_t s_d;
  cuvx_word_t v;
  logic take;

  assign sif.done = s_q.done;
  assign sif.hi_idx = s_q.hi_idx;
  assign sif.lo_idx = s_q.lo_idx;

  // Walks the cells upward one per cycle; strict compares keep the lower cell on a tie.
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    v = sif.data[s_q.idx];
    take = sif.incl[s_q.idx];
    unique case (s_q.st)
      CUVX_S_IDLE: begin
        if (sif.start) begin
          s_d.st = CUVX_S_RUN;
          s_d.idx = `CUVX_RST_IDX;
          s_d.any = 1'b0;
        end
      end
      CUVX_S_RUN: begin
        if (take) begin
          s_d.any = 1'b1;
          if (!s_q.any || cuvx_greater(v, s_q.hi_val, sif.sgn)) begin
            s_d.hi_val = v;
            s_d.hi_idx = s_q.idx + 4'h1;
          end
          if (!s_q.any || cuvx_greater(s_q.lo_val, v, sif.sgn)) begin
            s_d.lo_val = v;
            s_d.lo_idx = s_q.idx + 4'h1;
          end
        end
        if (s_q.idx == 4'(`CUVX_NCELL - 1)) begin
          s_d.st = CUVX_S_DONE;
        end else begin
          s_d.idx = s_q.idx + 4'h1;
        end
      end
      CUVX_S_DONE: begin
        if (!s_q.any) begin
          s_d.hi_idx = `CUVX_IDX_INVALID;
          s_d.lo_idx = `CUVX_IDX_INVALID;
        end
        s_d.done = 1'b1;
        s_d.st = CUVX_S_IDLE;
      end
      default: begin
        s_d.st = CUVX_S_IDLE;
      end
    endcase
  end

  // Registers the search state.
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '{st: CUVX_S_IDLE, idx: `CUVX_RST_IDX, any: 1'b0, hi_val: `CUVX_RST_WORD,
               lo_val: `CUVX_RST_WORD, hi_idx: `CUVX_RST_IDX, lo_idx: `CUVX_RST_IDX, done: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end
endmodule

/* File: rtl/cuvx_top.sv */
// Cell undervoltage alert and extremum index status block with APB registers.
// Notes on behaviour
// - Fourteen undervoltage flags sit in bits 13 to 0, cell n in bit n-1, bits 15 and 14 read zero.
// - A cell is flagged when its reading is below the unipolar threshold, or the bipolar one if its sign select is 1.
// - A cell is evaluated only while its low alert enable bit is 1, so a disabled cell never alerts.
// - Each acquisition rewrites the flags, so a resolved condition clears and a persisting one stays set.
// - The alert and extremum registers are read-only, reset to zero, and ignore writes.
// - After a scan the highest enabled cell number goes to bits 11 to 8.
// - After a scan the lowest enabled cell number goes to bits 3 to 0.
// - The extremum search uses either arithmetic results or filtered results per the filtered read select.
// - Extremum fields change only for acquisitions requested with sweep high.
// - On a tie the lowest cell number is reported for both fields.
// - The search covers only unipolar or only bipolar cells per the extremum set select.
// - When no scanned cell is in the selected set both fields read hexadecimal F.
// - The summary output is the OR of all fourteen undervoltage flags.
`timescale 1ns/1ps
`include "cuvx_cfg.svh"
module cuvx_top (
  input wire logic clock, // System clock, 200 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [`CUVX_ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped addresses.
  input wire logic acq_valid, // Acquisition results are valid this cycle.
  input wire logic acq_sweep, // The acquisition was requested as a scan.
  input wire cuvx_pkg::cuvx_cells_t alu_data, // Arithmetic unit result per cell.
  input wire cuvx_pkg::cuvx_cells_t iir_data, // Filtered result per cell.
  output logic acq_ready, // Block can take an acquisition.
  output logic low_alert_summary, // OR of all undervoltage flags.
  output logic irq // Level interrupt.
);
  import cuvx_pkg::*;

  cuvx_main_t m_q;
  cuvx_main_t m_d;
  cuvx_search_if sif ();
  logic [7:0] ridx;
  logic mapped;
  logic wr;
  logic [`CUVX_NEV-1:0] ev;
  logic [`CUVX_NCELL-1:0] fresh;

  // Returns the register index of a word-aligned address, or all ones when out of range.
  function automatic logic [7:0] cuvx_index(input logic [`CUVX_ADDR_W-1:0] a);
    if (a[1:0] != 2'b00 || a[`CUVX_ADDR_W-1:10] != 2'b00) begin
      cuvx_index = 8'hff;
    end else begin
      cuvx_index = a[9:2];
    end
  endfunction

  // Tells whether one cell reading lies below its low threshold.
  function automatic logic cuvx_below(input cuvx_word_t v, input logic bip, input cuvx_word_t ut,
                                      input cuvx_word_t bt);
    cuvx_below = bip ? cuvx_greater(bt, v, 1'b1) : cuvx_greater(ut, v, 1'b0);
  endfunction

  cuvx_extremum u_search (
    .clock(clock),
    .rst(rst),
    .sif(sif)
  );

  // Presents the captured acquisition to the search engine.
  assign sif.start = m_q.start;
  assign sif.data = m_q.data;
  assign sif.incl = m_q.incl;
  assign sif.sgn = m_q.sgn;

  // Top-level outputs come straight from the state register.
  assign prdata = m_q.prdata;
  assign pready = m_q.pready;
  assign pslverr = m_q.pslverr;
  assign acq_ready = m_q.st[0];
  assign low_alert_summary = m_q.summary;
  assign irq = m_q.irq;

  // Decodes the bus and computes every next-state value.
  always_comb begin
    m_d = m_q;
    ridx = cuvx_index(paddr);
    mapped = 1'b0;
    wr = psel && penable && pwrite && m_q.pready;
    ev = '0;
    fresh = '0;
    m_d.start = 1'b0;

    // Setup cycle: the read word and the error answer are prepared for the access phase.
    m_d.pready = psel && !penable;
    m_d.prdata = 32'h0000_0000;
    if (psel && !penable) begin
      unique case (ridx)
        `CUVX_IDX_ALERTS: begin
          m_d.prdata = {18'h00000, m_q.alerts};
          mapped = 1'b1;
        end
        `CUVX_IDX_EXTREMUM: begin
          m_d.prdata[`CUVX_HI_LSB +: `CUVX_IDX_W] = m_q.hi;
          m_d.prdata[`CUVX_LO_LSB +: `CUVX_IDX_W] = m_q.lo;
          mapped = 1'b1;
        end
        `CUVX_IDX_UTHR: begin
          m_d.prdata = {16'h0000, m_q.uthr};
          mapped = 1'b1;
        end
        `CUVX_IDX_BTHR: begin
          m_d.prdata = {16'h0000, m_q.bthr};
          mapped = 1'b1;
        end
        `CUVX_IDX_ALERT_EN: begin
          m_d.prdata = {18'h00000, m_q.alert_en};
          mapped = 1'b1;
        end
        `CUVX_IDX_POLARITY: begin
          m_d.prdata = {18'h00000, m_q.pol};
          mapped = 1'b1;
        end
        `CUVX_IDX_CELL_EN: begin
          m_d.prdata = {18'h00000, m_q.cell_en};
          mapped = 1'b1;
        end
        `CUVX_IDX_CTRL: begin
          m_d.prdata[`CUVX_CTRL_FILT] = m_q.filt;
          m_d.prdata[`CUVX_CTRL_SET] = m_q.set_sel;
          mapped = 1'b1;
        end
        `CUVX_IDX_IRQ_STAT: begin
          m_d.prdata[`CUVX_NEV-1:0] = m_q.irq_stat;
          mapped = 1'b1;
        end
        `CUVX_IDX_IRQ_MASK: begin
          m_d.prdata[`CUVX_NEV-1:0] = m_q.irq_mask;
          mapped = 1'b1;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
    end
    m_d.pslverr = psel && !penable && !mapped;

    // Access edge: writable registers load; the two status registers have no write path.
    if (wr && !m_q.pslverr) begin
      unique case (ridx)
        `CUVX_IDX_UTHR: m_d.uthr = pwdata[`CUVX_WORD_W-1:0];
        `CUVX_IDX_BTHR: m_d.bthr = pwdata[`CUVX_WORD_W-1:0];
        `CUVX_IDX_ALERT_EN: m_d.alert_en = pwdata[`CUVX_NCELL-1:0];
        `CUVX_IDX_POLARITY: m_d.pol = pwdata[`CUVX_NCELL-1:0];
        `CUVX_IDX_CELL_EN: m_d.cell_en = pwdata[`CUVX_NCELL-1:0];
        `CUVX_IDX_CTRL: begin
          m_d.filt = pwdata[`CUVX_CTRL_FILT];
          m_d.set_sel = pwdata[`CUVX_CTRL_SET];
        end
        `CUVX_IDX_IRQ_MASK: m_d.irq_mask = pwdata[`CUVX_NEV-1:0];
        default: m_d.irq_mask = m_q.irq_mask;
      endcase
    end

    // Acquisition flow: capture, search, then commit everything in one cycle.
    unique case (m_q.st)
      CUVX_M_IDLE: begin
        if (acq_valid) begin
          for (int i = 0; i < `CUVX_NCELL; i++) begin
            m_d.pend[i] = m_q.alert_en[i] && cuvx_below(alu_data[i], m_q.pol[i], m_q.uthr, m_q.bthr);
          end
          m_d.data = m_q.filt ? iir_data : alu_data;
          m_d.incl = m_q.cell_en & (m_q.set_sel ? m_q.pol : ~m_q.pol);
          m_d.sgn = m_q.set_sel;
          m_d.sweep = acq_sweep;
          m_d.start = 1'b1;
          m_d.st = CUVX_M_WAIT;
        end
      end
      CUVX_M_WAIT: begin
        if (sif.done) begin
          fresh = m_q.pend & ~m_q.alerts;
          m_d.alerts = m_q.pend;
          if (m_q.sweep) begin
            m_d.hi = sif.hi_idx;
            m_d.lo = sif.lo_idx;
            ev[`CUVX_EV_INVALID] = (sif.hi_idx == `CUVX_IDX_INVALID);
          end
          ev[`CUVX_EV_ACQ] = 1'b1;
          ev[`CUVX_EV_ALERT] = |fresh;
          m_d.st = CUVX_M_IDLE;
        end
      end
      default: begin
        m_d.st = CUVX_M_IDLE;
      end
    endcase

    m_d.summary = |m_d.alerts;

    // Sticky events: a write of one clears, but a new event in the same cycle wins.
    if (wr && !m_q.pslverr && ridx == `CUVX_IDX_IRQ_STAT) begin
      m_d.irq_stat = m_q.irq_stat & ~pwdata[`CUVX_NEV-1:0];
    end
    m_d.irq_stat = m_d.irq_stat | ev;
    m_d.irq = |(m_d.irq_stat & m_d.irq_mask);
  end

  // Registers the whole block state; everything resets to zero or idle.
  always_ff @(posedge clock) begin
    if (rst) begin
      m_q <= '{st: CUVX_M_IDLE, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
               uthr: `CUVX_RST_WORD, bthr: `CUVX_RST_WORD, alert_en: `CUVX_RST_CELLS,
               pol: `CUVX_RST_CELLS, cell_en: `CUVX_RST_CELLS, filt: 1'b0, set_sel: 1'b0,
               irq_stat: 3'h0, irq_mask: 3'h0, irq: 1'b0, summary: 1'b0,
               alerts: `CUVX_RST_CELLS, pend: `CUVX_RST_CELLS, hi: `CUVX_RST_IDX, lo: `CUVX_RST_IDX,
               sweep: 1'b0, start: 1'b0, incl: `CUVX_RST_CELLS, sgn: 1'b0, data: '0};
    end else begin
      m_q <= m_d;
    end
  end
endmodule

/* File: test/cuvx_top_chk.sv */
// Port-level assertions for the cell undervoltage status block.
`timescale 1ns/1ps
`include "cuvx_cfg.svh"
module cuvx_top_chk (
  input wire logic clock, // Clock.
  input wire logic rst, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Direction.
  input wire logic [`CUVX_ADDR_W-1:0] paddr, // Address.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic acq_valid, // Acquisition offer.
  input wire logic acq_ready, // Acquisition idle.
  input wire logic low_alert_summary, // Summary flag.
  input wire logic irq // Interrupt.
);
  // All checks run on the one clock and pause during reset.
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("ready missing after setup");
  ready_one_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  alert_rsvd_a: assert property (pready && !pwrite && paddr == 12'h024 |-> prdata[31:14] == 18'h0)
    else $error("reserved alert bits set");
  ext_rsvd_a: assert property (pready && !pwrite && paddr == 12'h028 |-> !prdata[31:12] && !prdata[7:4])
    else $error("reserved extremum bits set");
  sum_or_a: assert property (pready && !pwrite && paddr == 12'h024 && $past(acq_ready) |-> low_alert_summary == |prdata[13:0])
    else $error("summary differs from flags");
  acq_time_a: assert property (acq_valid && acq_ready |=> (!acq_ready) [*8] ##1 (!acq_ready) [*8] ##1 !acq_ready ##1 acq_ready)
    else $error("acquisition commit time wrong");
  sum_commit_a: assert property ($changed(low_alert_summary) |-> $rose(acq_ready))
    else $error("summary moved outside commit");
  irq_cause_a: assert property ($rose(irq) |-> $rose(acq_ready) || $past(pready && pwrite) || $past(pready && pwrite, 2))
    else $error("interrupt rose without cause");
endmodule
bind cuvx_top cuvx_top_chk u_cuvx_top_chk (.clock, .rst, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .acq_valid, .acq_ready, .low_alert_summary, .irq);

/* File: test/cuvx_top_tb.sv */
// Self-checking bench for the cell undervoltage status block.
`timescale 1ns/1ps
`include "cuvx_cfg.svh"
module cuvx_top_tb;
  import cuvx_pkg::*;
  typedef struct packed {
    logic sweep;
    logic [1:0] ctrl;
    logic [13:0] pol;
    logic [13:0] aen;
    logic [13:0] cen;
    logic [15:0] step;
    logic [13:0] al;
    logic [15:0] ext;
  } cuvx_row_t;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, acq_valid = 1'h0, acq_sweep = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, exp_ext = 32'h0;
  logic pready, pslverr, acq_ready, low_alert_summary, irq, er;
  logic [13:0] exp_al = 14'h0;
  cuvx_cells_t alu_data = '0, iir_data = '0;
  int num_errors = 0, n_tests = 0;
  // Each row: scan flag, control, sign select, alert enable, channel enable, cell step, then the expected
  // alert word and extremum word.
  cuvx_row_t rows [6] = '{'{1'h1, 2'h0, 14'h0000, 14'h3fff, 14'h3fff, 16'h0004, 14'h000f, 16'h0e01},
    '{1'h1, 2'h1, 14'h0000, 14'h0f0f, 14'h3ffe, 16'h0004, 14'h000f, 16'h020e},
    '{1'h0, 2'h0, 14'h3fff, 14'h3fff, 14'h3fff, 16'hfffc, 14'h0001, 16'h020e},
    '{1'h1, 2'h2, 14'h0000, 14'h3fff, 14'h3fff, 16'h0004, 14'h000f, 16'h0f0f},
    '{1'h1, 2'h2, 14'h2aaa, 14'h3fff, 14'h3fff, 16'h0000, 14'h3fff, 16'h0202},
    '{1'h1, 2'h0, 14'h0000, 14'h3fff, 14'h3fff, 16'h1234, 14'h3f01, 16'h0809}};
  always #2.5 clock = ~clock;
  cuvx_top u_cuvx_top (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .acq_valid, .acq_sweep, .alu_data, .iir_data, .acq_ready, .low_alert_summary, .irq);
  // Prints the counts and the verdict, then stops.
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Counts one comparison and reports a mismatch.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'h1) break;
    end
    if (i == 20) begin
      check(32'h0, 32'h1);
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Offers one acquisition and waits for its commit.
  task automatic acq(input logic s);
    int i;
    @(posedge clock);
    acq_valid <= 1'h1;
    acq_sweep <= s;
    @(posedge clock);
    acq_valid <= 1'h0;
    @(posedge clock);
    for (i = 0; i < 40 && acq_ready !== 1'h1; i++) @(posedge clock);
    if (i == 40) begin
      check(32'h0, 32'h1);
      finish_test();
    end
  endtask
  // Below test, signed for bipolar values.
  function automatic logic less(input logic [15:0] a, input logic [15:0] b, input logic sg);
    less = sg ? $signed(a) < $signed(b) : a < b;
  endfunction
  // Programs a row, runs it and compares both status words against the model.
  task automatic run_row(input cuvx_row_t r);
    logic [3:0] hi, lo;
    logic [13:0] set;
    logic [15:0] a;
    cuvx_cells_t v;
    int i;
    apb(1'h1, 12'h048, {18'h0, r.aen});
    apb(1'h1, 12'h04c, {18'h0, r.pol});
    apb(1'h1, 12'h050, {18'h0, r.cen});
    apb(1'h1, 12'h054, {30'h0, r.ctrl});
    for (i = 0; i < 14; i++) begin
      a = 16'h8000 + 16'(r.step * i);
      alu_data[i] <= a;
      iir_data[i] <= ~a;
      v[i] = r.ctrl[0] ? ~a : a;
      exp_al[i] = r.aen[i] && less(a, r.pol[i] ? 16'h0000 : 16'h8010, r.pol[i]);
    end
    set = r.cen & (r.ctrl[1] ? r.pol : ~r.pol);
    hi = 4'hf;
    lo = 4'hf;
    for (i = 0; i < 14; i++) begin
      if (set[i] && (hi == 4'hf || less(v[hi - 1], v[i], r.ctrl[1]))) hi = 4'(i + 1);
      if (set[i] && (lo == 4'hf || less(v[i], v[lo - 1], r.ctrl[1]))) lo = 4'(i + 1);
    end
    if (r.sweep) exp_ext = {20'h0, hi, 4'h0, lo};
    acq(r.sweep);
    apb(1'h0, 12'h024, 32'h0);
    check(rd, {18'h0, exp_al});
    check(rd, {18'h0, r.al});
    check({31'h0, low_alert_summary}, {31'h0, |exp_al});
    apb(1'h0, 12'h028, 32'h0);
    check(rd, exp_ext);
    check(rd, {16'h0, r.ext});
  endtask
  // Reset, table rows, then read-only, unmapped and interrupt cases.
  initial begin
    int i;
    repeat (12) @(posedge clock);
    rst <= 1'h0;
    apb(1'h0, 12'h024, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, 12'h028, 32'h0);
    check(rd, 32'h0);
    apb(1'h1, 12'h040, 32'h8010);
    apb(1'h1, 12'h044, 32'h0);
    for (i = 0; i < 6; i++) run_row(rows[i]);
    apb(1'h1, 12'h028, 32'hffffffff);
    check({31'h0, er}, 32'h0);
    apb(1'h1, 12'h024, 32'hffffffff);
    apb(1'h0, 12'h028, 32'h0);
    check(rd, exp_ext);
    apb(1'h0, 12'h024, 32'h0);
    check(rd, {18'h0, exp_al});
    apb(1'h0, 12'h030, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    apb(1'h0, 12'h058, 32'h0);
    check(rd, 32'h7);
    check({31'h0, irq}, 32'h0);
    apb(1'h1, 12'h05c, 32'h1);
    for (i = 0; i < 10 && irq !== 1'h1; i++) @(posedge clock);
    check({31'h0, irq}, 32'h1);
    apb(1'h1, 12'h058, 32'h7);
    for (i = 0; i < 10 && irq !== 1'h0; i++) @(posedge clock);
    check({31'h0, irq}, 32'h0);
    apb(1'h0, 12'h058, 32'h0);
    check(rd, 32'h0);
    // A scan raises the masked acquisition event, then a reset after its commit must clear every status output.
    acq(1'h1);
    check({31'h0, irq}, 32'h1);
    check({31'h0, low_alert_summary}, 32'h1);
    rst <= 1'h1;
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    check({31'h0, acq_ready}, 32'h1);
    check({31'h0, low_alert_summary}, 32'h0);
    check({31'h0, irq}, 32'h0);
    apb(1'h0, 12'h024, 32'h0);
    check(rd, 32'h0);
    apb(1'h0, 12'h028, 32'h0);
    check(rd, 32'h0);
    finish_test();
  end
endmodule
